/* cpoc_fifo.sv */
// word buffer between memory fetch and the data pins
// assumes synchronous flush and a clock enable shared with the caller
`timescale 1ns/1ps
module cpoc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // buffer ports
  cpoc_fifo_if.fifo bus
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
  } cpoc_fifo_st_t;

  cpoc_fifo_st_t st_ff;
  cpoc_fifo_st_t nxt_st;
  logic push;
  logic pop;

  // full and empty from the count, so they never lie
  assign bus.in_ready = (st_ff.count != (PW+1)'(DEPTH));
  assign bus.out_valid = (st_ff.count != '0);
  assign bus.out_data = st_ff.mem[st_ff.rd];

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  always_comb begin
    nxt_st = st_ff;
    push = bus.in_valid && bus.in_ready;
    pop = bus.out_ready && bus.out_valid;
    if (bus.flush) begin
      // flush wins, a push in the same cycle is dropped on purpose
      nxt_st.wr = '0;
      nxt_st.rd = '0;
      nxt_st.count = '0;
    end else begin
      if (push) begin
        nxt_st.mem[st_ff.wr] = bus.in_data;
        nxt_st.wr = ptr_inc(st_ff.wr);
      end
      if (pop) begin
        nxt_st.rd = ptr_inc(st_ff.rd);
      end
      if (push && !pop) begin
        nxt_st.count = st_ff.count + (PW+1)'(1);
      end else if (pop && !push) begin
        nxt_st.count = st_ff.count - (PW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

endmodule : cpoc_fifo

/* cpoc_fifo_if.sv */
// valid/ready carrier between the output control and its word buffer
// assumes producer and consumer share one clock
`timescale 1ns/1ps
interface cpoc_fifo_if #(
  parameter int unsigned W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic flush;

  modport fifo (
    input in_valid, in_data, out_ready, flush,
    output in_ready, out_valid, out_data
  );

  modport user (
    output in_valid, in_data, out_ready, flush,
    input in_ready, out_valid, out_data
  );
endinterface : cpoc_fifo_if

/* cpoc_pkg.sv */
// constants and types of the configuration memory output control block
// assumes a 25 MHz system clock and one memory word per address
package cpoc_pkg;

  // clock and timing
  localparam int unsigned CPOC_CLK_MHZ = 25;
  localparam int unsigned CPOC_REL_DELAY_MIN_US = 500;
  localparam int unsigned CPOC_REL_DELAY_MAX_SER_US = 3000;
  localparam int unsigned CPOC_REL_DELAY_MAX_PAR_US = 30000;
  localparam int unsigned CPOC_BROWNOUT_MIN_US = 10000;
  // least times, exact whole cycles at this rate
  localparam int unsigned CPOC_REL_DELAY_CYC = CPOC_REL_DELAY_MIN_US * CPOC_CLK_MHZ;
  localparam int unsigned CPOC_BROWNOUT_CYC = CPOC_BROWNOUT_MIN_US * CPOC_CLK_MHZ;
  localparam int unsigned CPOC_CNT_W = 18;

  // data path
  localparam int unsigned CPOC_DATA_W = 8;
  localparam int unsigned CPOC_ADDR_W = 12;
  localparam int unsigned CPOC_FIFO_DEPTH = 4;
  localparam int unsigned CPOC_REV_W = 2;

  // power-on state, gray along ramp, delay, up
  typedef enum logic [1:0] {
    CPOC_PWR_RAMP = 2'h0,
    CPOC_PWR_DELAY = 2'h1,
    CPOC_PWR_UP = 2'h3
  } cpoc_pwr_t;

  // streaming state, gray along idle, load, stream, end
  typedef enum logic [1:0] {
    CPOC_STR_IDLE = 2'h0,
    CPOC_STR_LOAD = 2'h1,
    CPOC_STR_RUN = 2'h3,
    CPOC_STR_END = 2'h2
  } cpoc_str_t;

  // pin inputs that pass the synchroniser
  typedef struct packed {
    logic chip_enable_n;
    logic oe_reset_in;
    logic reconfiguration_strobe;
    logic busy;
    logic core_supply_ok;
    logic core_supply_low;
    logic io_supply_ok;
    logic variant_parallel;
    logic parallel_mode;
    logic decompress_en;
    logic revisioning_en;
    logic [CPOC_REV_W-1:0] rev_sel;
  } cpoc_pins_t;

  localparam cpoc_pins_t CPOC_PINS_RST = '0;

endpackage : cpoc_pkg

/* cpoc_target_model.sv */
// target device model: shared reset line, busy throttle, storage words
// assumes an external pull-up on the line and same-cycle storage reads
`timescale 1ns/1ps
module cpoc_target_model #(
  parameter int unsigned ADDR_W = 12
) (
  // shared line
  input wire logic oe_reset_oe,
  input wire logic hold_low,
  output logic line,
  // throttle
  input wire logic busy_req,
  output logic busy,
  // storage
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_rdata
);
  // pull-up wins unless a party pulls low; target starts once high
  assign line = !(oe_reset_oe || hold_low);
  // no jtag pins modelled, so nothing pulls them low in standby
  assign busy = busy_req;
  // address-derived words so a wrong address shows as wrong data
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[ADDR_W-1:ADDR_W-8];
endmodule : cpoc_target_model

/* cpoc_top.sv */
// output control of a configuration memory streaming to a target device
// assumes pins are asynchronous, storage answers mem_rdata in the same cycle
// as mem_addr, and an external pull-up on the shared reset line
// Operation
// - hold reset line low while supplies ramp
// - wait release delay after thresholds before release
// - release delay 0.5 ms least, 3/30 ms most
// - parallel variant also waits for io supply
// - core supply loss resets and holds line low
// - brown-out only after 10 ms below threshold
// - reset line polarity fixed active low
// - line low: counter reset, cascade high, float
// - chip enable high: standby, reset, cascade high
// - end address is revision's last location
// - parallel at terminal: hold, float, cascade low
// - busy high: hold address and data, clock runs
// - strobe rise or reset: counter to start
// - busy honoured only parallel, no decompression
// - two-bit revision number selects the bank
`timescale 1ns/1ps
module cpoc_top
  import cpoc_pkg::*;
#(
  parameter int unsigned DATA_W = cpoc_pkg::CPOC_DATA_W,
  parameter int unsigned ADDR_W = cpoc_pkg::CPOC_ADDR_W,
  parameter int unsigned FIFO_DEPTH = cpoc_pkg::CPOC_FIFO_DEPTH,
  parameter int unsigned REL_DELAY_CYC = cpoc_pkg::CPOC_REL_DELAY_CYC,
  parameter int unsigned BROWNOUT_CYC = cpoc_pkg::CPOC_BROWNOUT_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // control pins
  input wire logic chip_enable_n,
  input wire logic oe_reset_in,
  input wire logic reconfiguration_strobe,
  input wire logic busy,
  // supply monitors
  input wire logic core_supply_ok,
  input wire logic core_supply_low,
  input wire logic io_supply_ok,
  // straps
  input wire logic variant_parallel,
  input wire logic parallel_mode,
  input wire logic decompress_en,
  input wire logic revisioning_en,
  input wire logic [cpoc_pkg::CPOC_REV_W-1:0] rev_sel,
  // storage read port
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_rdata,
  // shared open-drain reset line
  output logic oe_reset_out,
  output logic oe_reset_oe,
  // configuration data and clock
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic clock_out,
  output logic clock_out_oe,
  // cascade and status
  output logic cascade_enable_out_n,
  output logic standby,
  output logic [ADDR_W-1:0] address
);
  import cpoc_pkg::*;

  localparam int unsigned BANK_W = ADDR_W - CPOC_REV_W;
  localparam logic [ADDR_W-1:0] TERMINAL_COUNT = '1;
  localparam logic [CPOC_CNT_W-1:0] REL_LAST = CPOC_CNT_W'(REL_DELAY_CYC - 1);
  localparam logic [CPOC_CNT_W-1:0] BO_LAST = CPOC_CNT_W'(BROWNOUT_CYC - 1);

  typedef struct packed {
    cpoc_pins_t s1;
    cpoc_pins_t s2;
    cpoc_pwr_t pwr;
    logic [CPOC_CNT_W-1:0] rel_cnt;
    logic [CPOC_CNT_W-1:0] bo_cnt;
    cpoc_str_t str;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] fetch_addr;
    logic fetch_done;
    logic [CPOC_REV_W-1:0] rev;
    logic strobe_d;
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic clk;
    logic clk_oe;
    logic ceo_n;
    logic oer_out;
    logic oer_oe;
    logic standby;
  } cpoc_st_t;

  localparam cpoc_st_t ST_RST = '{
    s1: CPOC_PINS_RST,
    s2: CPOC_PINS_RST,
    pwr: CPOC_PWR_RAMP,
    rel_cnt: '0,
    bo_cnt: '0,
    str: CPOC_STR_IDLE,
    addr: '0,
    fetch_addr: '0,
    fetch_done: 1'b0,
    rev: '0,
    strobe_d: 1'b0,
    data: '0,
    data_oe: 1'b0,
    clk: 1'b0,
    clk_oe: 1'b0,
    ceo_n: 1'b1,
    oer_out: 1'b0,
    oer_oe: 1'b1,
    standby: 1'b0
  };

  cpoc_st_t st_ff;
  cpoc_st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;

  cpoc_fifo_if #(.W(DATA_W)) fq ();

  cpoc_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .bus(fq)
  );

  // revision bank bounds, bank = revision number in the top address bits
  function automatic logic [ADDR_W-1:0] bank_start(input logic [CPOC_REV_W-1:0] r,
                                                   input logic rev_on);
    bank_start = rev_on ? {r, {BANK_W{1'b0}}} : '0;
  endfunction : bank_start

  function automatic logic [ADDR_W-1:0] bank_end(input logic [CPOC_REV_W-1:0] r,
                                                 input logic rev_on);
    bank_end = rev_on ? {r, {BANK_W{1'b1}}} : TERMINAL_COUNT;
  endfunction : bank_end

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else if (clk_en) begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // decode of the synchronised pins, used by the state update below
  logic rev_on;
  logic busy_on;
  logic par;
  logic supplies_ok;
  logic line_low;
  logic hold_rst;
  logic strobe_rise;
  logic tick;
  logic [ADDR_W-1:0] lim;
  logic [ADDR_W-1:0] start;

  always_comb begin
    par = st_ff.s2.variant_parallel;
    rev_on = par && st_ff.s2.revisioning_en;
    // busy only means something in plain parallel output
    busy_on = par && st_ff.s2.parallel_mode && !st_ff.s2.decompress_en;
    // a sagging core never counts as good, so the line stays low until it recovers
    supplies_ok = st_ff.s2.core_supply_ok && !st_ff.s2.core_supply_low &&
      (!par || st_ff.s2.io_supply_ok);
    // the sampled line also shows an outside monitor holding it low
    line_low = !st_ff.s2.oe_reset_in || st_ff.oer_oe;
    hold_rst = st_ff.s2.chip_enable_n || line_low || (st_ff.pwr != CPOC_PWR_UP);
    strobe_rise = par && st_ff.s2.reconfiguration_strobe && !st_ff.strobe_d;
    tick = st_ff.clk;
    start = bank_start(st_ff.rev, rev_on);
    lim = par ? bank_end(st_ff.rev, rev_on) : TERMINAL_COUNT;
  end

  always_comb begin
    nxt_st = st_ff;
    fq.flush = 1'b0;
    fq.in_valid = 1'b0;
    fq.in_data = mem_rdata;
    fq.out_ready = 1'b0;

    // pin synchroniser, first stage read only by the second
    nxt_st.s1.chip_enable_n = chip_enable_n;
    nxt_st.s1.oe_reset_in = oe_reset_in;
    nxt_st.s1.reconfiguration_strobe = reconfiguration_strobe;
    nxt_st.s1.busy = busy;
    nxt_st.s1.core_supply_ok = core_supply_ok;
    nxt_st.s1.core_supply_low = core_supply_low;
    nxt_st.s1.io_supply_ok = io_supply_ok;
    nxt_st.s1.variant_parallel = variant_parallel;
    nxt_st.s1.parallel_mode = parallel_mode;
    nxt_st.s1.decompress_en = decompress_en;
    nxt_st.s1.revisioning_en = revisioning_en;
    nxt_st.s1.rev_sel = rev_sel;
    nxt_st.s2 = st_ff.s1;
    nxt_st.strobe_d = st_ff.s2.reconfiguration_strobe;

    // power-on and brown-out; the line is only ever pulled low
    nxt_st.oer_out = 1'b0;
    case (st_ff.pwr)
      CPOC_PWR_RAMP: begin
        nxt_st.rel_cnt = '0;
        if (supplies_ok) begin
          nxt_st.pwr = CPOC_PWR_DELAY;
        end
      end
      CPOC_PWR_DELAY: begin
        // release at the least delay, well inside both longest limits
        if (!supplies_ok) begin
          nxt_st.pwr = CPOC_PWR_RAMP;
        end else if (st_ff.rel_cnt == REL_LAST) begin
          nxt_st.pwr = CPOC_PWR_UP;
        end else begin
          nxt_st.rel_cnt = st_ff.rel_cnt + CPOC_CNT_W'(1);
        end
      end
      CPOC_PWR_UP: begin
        nxt_st.pwr = CPOC_PWR_UP;
      end
      default: begin
        nxt_st.pwr = CPOC_PWR_RAMP;
      end
    endcase
    // short dips are filtered, only a long sag resets
    if (st_ff.s2.core_supply_low) begin
      if (st_ff.bo_cnt == BO_LAST) begin
        nxt_st.pwr = CPOC_PWR_RAMP;
        nxt_st.bo_cnt = '0;
      end else begin
        nxt_st.bo_cnt = st_ff.bo_cnt + CPOC_CNT_W'(1);
      end
    end else begin
      nxt_st.bo_cnt = '0;
    end
    nxt_st.oer_oe = (nxt_st.pwr != CPOC_PWR_UP);

    nxt_st.standby = st_ff.s2.chip_enable_n;

    // output clock runs free; only its enable changes
    nxt_st.clk = !st_ff.clk;

    // memory fetch into the buffer, stalls when the buffer is full
    if (st_ff.str != CPOC_STR_IDLE && !st_ff.fetch_done) begin
      fq.in_valid = 1'b1;
      if (fq.in_ready) begin
        if (st_ff.fetch_addr == lim) begin
          nxt_st.fetch_done = 1'b1;
        end else begin
          nxt_st.fetch_addr = st_ff.fetch_addr + ADDR_W'(1);
        end
      end
    end

    // address counter; reset first, then busy, then increment
    if (hold_rst) begin
      // revision is taken while the counter is held
      nxt_st.rev = st_ff.s2.rev_sel;
      nxt_st.str = CPOC_STR_IDLE;
      nxt_st.addr = bank_start(st_ff.s2.rev_sel, rev_on);
      nxt_st.fetch_addr = bank_start(st_ff.s2.rev_sel, rev_on);
      nxt_st.fetch_done = 1'b0;
      nxt_st.data_oe = 1'b0;
      nxt_st.clk_oe = 1'b0;
      nxt_st.ceo_n = 1'b1;
      fq.flush = 1'b1;
    end else if (strobe_rise) begin
      // restart from the bank start, pins stay driven
      nxt_st.rev = st_ff.s2.rev_sel;
      nxt_st.str = CPOC_STR_LOAD;
      nxt_st.addr = bank_start(st_ff.s2.rev_sel, rev_on);
      nxt_st.fetch_addr = bank_start(st_ff.s2.rev_sel, rev_on);
      nxt_st.fetch_done = 1'b0;
      nxt_st.ceo_n = 1'b1;
      fq.flush = 1'b1;
    end else begin
      case (st_ff.str)
        CPOC_STR_IDLE: begin
          nxt_st.str = CPOC_STR_LOAD;
          nxt_st.addr = start;
        end
        CPOC_STR_LOAD: begin
          // first word shows without moving the counter
          if (tick && fq.out_valid) begin
            fq.out_ready = 1'b1;
            nxt_st.data = fq.out_data;
            nxt_st.data_oe = 1'b1;
            nxt_st.clk_oe = par;
            nxt_st.str = CPOC_STR_RUN;
          end
        end
        CPOC_STR_RUN: begin
          if (busy_on && st_ff.s2.busy) begin
            // word and counter hold, clock keeps going
            nxt_st.clk_oe = 1'b1;
          end else if (par && !st_ff.s2.reconfiguration_strobe) begin
            nxt_st.addr = st_ff.addr;
          end else if (tick && fq.out_valid) begin
            fq.out_ready = 1'b1;
            nxt_st.addr = st_ff.addr + ADDR_W'(1);
            nxt_st.data = fq.out_data;
            if (st_ff.addr + ADDR_W'(1) == lim) begin
              nxt_st.str = CPOC_STR_END;
              nxt_st.data_oe = 1'b0;
              nxt_st.clk_oe = 1'b0;
              // only the last location of the memory passes the chain on
              nxt_st.ceo_n = (lim != TERMINAL_COUNT);
            end
          end
        end
        CPOC_STR_END: begin
          nxt_st.data_oe = 1'b0;
          nxt_st.clk_oe = 1'b0;
          nxt_st.ceo_n = (st_ff.addr != TERMINAL_COUNT);
        end
        default: begin
          nxt_st.str = CPOC_STR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign mem_addr = st_ff.fetch_addr;
  assign oe_reset_out = st_ff.oer_out;
  assign oe_reset_oe = st_ff.oer_oe;
  assign data_out = st_ff.data;
  assign data_oe = st_ff.data_oe;
  assign clock_out = st_ff.clk;
  assign clock_out_oe = st_ff.clk_oe;
  assign cascade_enable_out_n = st_ff.ceo_n;
  assign standby = st_ff.standby;
  assign address = st_ff.addr;

endmodule : cpoc_top

/* cpoc_top_asserts.sv */
// pin-level checker for the output control block
// assumes binding into cpoc_top with sys_clk rising edge and nrst low reset
`timescale 1ns/1ps
module cpoc_chk #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DATA_W = 8,
  parameter int unsigned REL_DELAY_CYC = cpoc_pkg::CPOC_REL_DELAY_CYC,
  parameter int unsigned BROWNOUT_CYC = cpoc_pkg::CPOC_BROWNOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // watched inputs
  input wire logic chip_enable_n,
  input wire logic oe_reset_in,
  input wire logic busy,
  input wire logic core_supply_ok,
  input wire logic core_supply_low,
  input wire logic io_supply_ok,
  input wire logic variant_parallel,
  input wire logic parallel_mode,
  input wire logic decompress_en,
  // watched outputs
  input wire logic oe_reset_out,
  input wire logic oe_reset_oe,
  input wire logic data_oe,
  input wire logic clock_out_oe,
  input wire logic cascade_enable_out_n,
  input wire logic standby,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] data_out
);
  // run lengths of good and low supply, too long for repetition
  int unsigned ok_cnt;
  int unsigned low_cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ok_cnt <= 0;
      low_cnt <= 0;
    end else begin
      ok_cnt <= (core_supply_ok && !core_supply_low && (io_supply_ok || !variant_parallel)) ?
        ok_cnt + 1 : 0;
      low_cnt <= core_supply_low ? low_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_line_only_low: assert property (!oe_reset_out)
    else $error("reset line driven high");
  a_release_min: assert property ($fell(oe_reset_oe) |-> ok_cnt >= REL_DELAY_CYC)
    else $error("reset line released early");
  a_release_max: assert property (ok_cnt == REL_DELAY_CYC + 8 |-> !oe_reset_oe)
    else $error("reset line released late");
  a_brownout_min: assert property ($rose(oe_reset_oe) |-> low_cnt >= BROWNOUT_CYC)
    else $error("brown-out taken too soon");
  a_brownout_max: assert property (low_cnt == BROWNOUT_CYC + 8 |-> oe_reset_oe)
    else $error("brown-out not taken");
  a_line_low_floats: assert property (!oe_reset_in [*4] |=>
    !data_oe && cascade_enable_out_n)
    else $error("outputs driven while line low");
  a_standby_floats: assert property (chip_enable_n [*4] |=> standby &&
    cascade_enable_out_n && !data_oe && !clock_out_oe && address[ADDR_W-3:0] == '0)
    else $error("standby outputs wrong");
  a_cascade_at_tc: assert property (!cascade_enable_out_n |->
    &address && !data_oe && !clock_out_oe)
    else $error("cascade low off terminal count");
  a_clock_parallel: assert property (clock_out_oe |-> data_oe && variant_parallel)
    else $error("clock out driven wrongly");
  a_addr_step_one: assert property (data_oe && $past(data_oe) && address != $past(address)
    |-> address == $past(address) + 1'h1 || address[ADDR_W-3:0] == '0)
    else $error("address jumped");
  a_busy_holds: assert property ((busy && variant_parallel && parallel_mode &&
    !decompress_en) [*4] |=> $stable(address) && $stable(data_out) && $stable(data_oe))
    else $error("busy did not hold data");
endmodule : cpoc_chk

bind cpoc_top cpoc_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .REL_DELAY_CYC(REL_DELAY_CYC),
  .BROWNOUT_CYC(BROWNOUT_CYC)) chk_u (.sys_clk(sys_clk), .nrst(nrst),
  .chip_enable_n(chip_enable_n), .oe_reset_in(oe_reset_in), .busy(busy),
  .core_supply_ok(core_supply_ok), .core_supply_low(core_supply_low),
  .io_supply_ok(io_supply_ok), .variant_parallel(variant_parallel),
  .parallel_mode(parallel_mode), .decompress_en(decompress_en), .oe_reset_out(oe_reset_out),
  .oe_reset_oe(oe_reset_oe), .data_oe(data_oe), .clock_out_oe(clock_out_oe),
  .cascade_enable_out_n(cascade_enable_out_n), .standby(standby), .address(address),
  .data_out(data_out));

/* testbench.sv */
// self-checking bench for the output control block
// assumes short release and brown-out counts for a quick run
`timescale 1ns/1ps
module testbench;
  import cpoc_pkg::*;
  localparam int REL = 8;
  localparam int BRN = 16;
  int error_cnt = 0;
  int total_checks = 0;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic clk_en = 1'h1;
  logic chip_enable_n = 1'h0;
  logic reconfiguration_strobe = 1'h1;
  logic core_supply_ok = 1'h0;
  logic core_supply_low = 1'h0;
  logic io_supply_ok = 1'h0;
  logic variant_parallel = 1'h1;
  logic parallel_mode = 1'h0;
  logic decompress_en = 1'h0;
  logic revisioning_en = 1'h0;
  logic [1:0] rev_sel = 2'h0;
  logic hold_low = 1'h0;
  logic busy_req = 1'h0;
  logic line;
  logic busy;
  logic standby;
  logic data_oe;
  logic clock_out_oe;
  logic clock_out;
  logic cascade_enable_out_n;
  logic oe_reset_oe;
  logic [11:0] mem_addr;
  logic [11:0] address;
  logic [7:0] mem_rdata;
  logic [7:0] data_out;

  always #20 sys_clk = ~sys_clk;

  cpoc_top #(.REL_DELAY_CYC(REL), .BROWNOUT_CYC(BRN)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
    .clk_en(clk_en), .chip_enable_n(chip_enable_n), .oe_reset_in(line),
    .reconfiguration_strobe(reconfiguration_strobe), .busy(busy),
    .core_supply_ok(core_supply_ok), .core_supply_low(core_supply_low),
    .io_supply_ok(io_supply_ok), .variant_parallel(variant_parallel),
    .parallel_mode(parallel_mode), .decompress_en(decompress_en),
    .revisioning_en(revisioning_en), .rev_sel(rev_sel), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .oe_reset_out(), .oe_reset_oe(oe_reset_oe), .data_out(data_out),
    .data_oe(data_oe), .clock_out(clock_out), .clock_out_oe(clock_out_oe),
    .cascade_enable_out_n(cascade_enable_out_n), .standby(standby), .address(address));

  cpoc_target_model #(.ADDR_W(12)) target_u (.oe_reset_oe(oe_reset_oe), .hold_low(hold_low),
    .line(line), .busy_req(busy_req), .busy(busy), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  function automatic logic [7:0] word_of(logic [11:0] a);
    return a[7:0] ^ a[11:4];
  endfunction : word_of

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // bounded wait; a miss shows up as a mismatch
  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (sig !== lvl && n < lim);
    check("wait", sig, lvl);
  endtask : wait_lvl

  task automatic t_power();
    int n;
    tick(20);
    #1;
    check("ramp hold", oe_reset_oe, 1'h1);
    tick(1);
    core_supply_ok <= 1'h1;
    tick(30);
    #1;
    check("io wait", oe_reset_oe, 1'h1);
    tick(1);
    io_supply_ok <= 1'h1;
    wait_lvl(oe_reset_oe, 1'h0, 100, n);
    check("delay", n >= REL + 2 && n <= REL + 6, 1'h1);
  endtask : t_power

  task automatic t_brownout();
    int n;
    tick(1);
    core_supply_low <= 1'h1;
    tick(BRN / 2);
    core_supply_low <= 1'h0;
    tick(10);
    #1;
    check("short dip", oe_reset_oe, 1'h0);
    tick(1);
    core_supply_low <= 1'h1;
    wait_lvl(oe_reset_oe, 1'h1, 100, n);
    check("brownout", n >= BRN, 1'h1);
    tick(8);
    #1;
    check("held low", oe_reset_oe, 1'h1);
    tick(1);
    core_supply_low <= 1'h0;
    wait_lvl(oe_reset_oe, 1'h0, 100, n);
    check("regain", n >= REL, 1'h1);
  endtask : t_brownout

  task automatic t_standby();
    tick(1);
    chip_enable_n <= 1'h1;
    tick(6);
    #1;
    check("standby", {standby, cascade_enable_out_n, data_oe, clock_out_oe}, 4'hC);
    check("stby addr", address, 12'h000);
    tick(1);
    chip_enable_n <= 1'h0;
    hold_low <= 1'h1;
    tick(8);
    #1;
    check("line low", {standby, cascade_enable_out_n, data_oe, clock_out_oe}, 4'h4);
    check("held addr", address, 12'h000);
    tick(1);
    hold_low <= 1'h0;
    variant_parallel <= 1'h0;
  endtask : t_standby

  task automatic t_serial();
    int n;
    logic [11:0] a;
    wait_lvl(data_oe, 1'h1, 40, n);
    check("first word", data_out, word_of(address));
    check("no clock", clock_out_oe, 1'h0);
    // enable low must freeze the stream mid-run
    tick(1);
    clk_en <= 1'h0;
    #1;
    a = address;
    tick(8);
    #1;
    check("frozen addr", address, a);
    check("frozen word", data_out, word_of(a));
    tick(1);
    clk_en <= 1'h1;
    wait_lvl(cascade_enable_out_n, 1'h0, 9000, n);
    check("serial tc", {address, data_oe}, {12'hFFF, 1'h0});
  endtask : t_serial

  task automatic t_busy();
    logic [11:0] a;
    logic c;
    tick(1);
    busy_req <= 1'h1;
    tick(6);
    #1;
    a = address;
    tick(8);
    #1;
    check("busy addr", address, a);
    check("busy clock", clock_out_oe, 1'h1);
    c = clock_out;
    tick(1);
    #1;
    check("busy toggle", clock_out, !c);
    tick(1);
    busy_req <= 1'h0;
  endtask : t_busy

  task automatic t_parallel();
    int n;
    tick(1);
    chip_enable_n <= 1'h1;
    {variant_parallel, parallel_mode, revisioning_en} <= 3'h7;
    tick(4);
    chip_enable_n <= 1'h0;
    for (int r = 0; r < 4; r++) begin
      tick(1);
      rev_sel <= r[1:0];
      reconfiguration_strobe <= 1'h0;
      // busy is ignored once decompression is on
      decompress_en <= (r == 2);
      busy_req <= (r == 2);
      tick(4);
      reconfiguration_strobe <= 1'h1;
      tick(5);
      #1;
      check("bank start", address, {r[1:0], 10'h000});
      wait_lvl(data_oe, 1'h1, 40, n);
      check("word", data_out, word_of(address));
      check("clock on", clock_out_oe, 1'h1);
      if (r == 0) begin
        t_busy();
      end
      wait_lvl(data_oe, 1'h0, 3000, n);
      check("end addr", address, {r[1:0], 10'h3FF});
      check("cascade", cascade_enable_out_n, r != 3);
      check("clock off", clock_out_oe, 1'h0);
    end
  endtask : t_parallel

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // whole run is near 17000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end

  initial begin
    tick(3);
    nrst <= 1'h1;
    t_power();
    t_brownout();
    t_standby();
    t_serial();
    t_parallel();
    test_done();
  end
endmodule : testbench
